/* design/ophsp_pkg.sv */
// Purpose: Shared constants for the octet service port of the line device
// Assumes: 20 MHz clock; one octet-wide line symbol per symbol period
// Notes: Line symbols carry a control flag to mark delimiter symbols
package ophsp_pkg;

  // Clock and line timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SYM_CYCLES = 16; // Clocks per line symbol
  localparam int unsigned BITS_PER_SYM = 8;
  localparam int unsigned TOL_PPM = 100; // Worst-case timing tolerance
  localparam longint unsigned NOM_BPS =
    longint'(CLK_HZ) * BITS_PER_SYM / SYM_CYCLES;
  localparam longint unsigned MIN_BPS =
    NOM_BPS - (NOM_BPS * TOL_PPM + 999_999) / 1_000_000;

  // Framing: preamble, start and end delimiters, inter-frame silence
  localparam int unsigned PRE_SYMS = 7;
  localparam int unsigned IFG_SYMS = 12;
  localparam int unsigned OVERHEAD_BITS =
    (PRE_SYMS + 2 + IFG_SYMS) * BITS_PER_SYM;

  // Frame length limits in data octets
  localparam logic [10:0] MIN_OCTETS = 11'h048; // 72
  localparam logic [10:0] MAX_OCTETS = 11'h5FF; // 1535

  // Control symbol codes
  localparam logic [7:0] SYM_PRE = 8'h55;
  localparam logic [7:0] SYM_SOF = 8'hD5;
  localparam logic [7:0] SYM_EOF = 8'hFD;
  localparam logic [7:0] SYM_ABORT = 8'hF7;

  // Widths of the notice fields
  localparam int unsigned RATE_W = 32;
  localparam int unsigned OVH_W = 16;

  // Request classes
  typedef enum logic [1:0] {
    REQ_BEGIN = 2'h0,
    REQ_DATA = 2'h1,
    REQ_FINISH = 2'h2
  } ophsp_req_t;

  // Indication classes
  typedef enum logic [1:0] {
    IND_BEGIN = 2'h0,
    IND_DATA = 2'h1,
    IND_FINISH = 2'h2,
    IND_ERROR = 2'h3
  } ophsp_ind_t;

  // Confirm status
  typedef enum logic [1:0] {
    ST_OK = 2'h0,
    ST_SEQUENCE = 2'h1,
    ST_UNDERRUN = 2'h2,
    ST_LENGTH = 2'h3
  } ophsp_status_t;

  // Reset values
  localparam logic [7:0] OCTET_RST = 8'h00;
  localparam logic [10:0] LEN_RST = 11'h000;

endpackage : ophsp_pkg

/* design/ophsp_fifo.sv */
// Purpose: Small valid/ready FIFO between the request side and the line
// Assumes: Single clock; write and read may occur in the same cycle
// Notes: Read data is driven straight from storage at the read pointer, unregistered
`timescale 1ns/1ns
module ophsp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("ophsp_fifo: DEPTH must be a power of two, at least 2");
    end
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;

  // Honest full and empty from the occupancy count
  assign in_ready_out = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_out = (count_ff != '0);
  assign out_data_out = mem_ff[rd_ptr_ff];

  // Pointers and count
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage has no reset; it is only read while marked valid
  always_ff @(posedge clk_in) begin
    if (push) mem_ff[wr_ptr_ff] <= in_data_in;
  end

endmodule : ophsp_fifo

/* design/ophsp_port.sv */
// Purpose: Octet service port of a line device: framed transmit with
//   confirms, framed receive indications and a start-up notice
// Assumes: Link entity keeps one request outstanding; line symbols arrive
//   already decoded, one per strobe, synchronous to clk_in
// Notes: Data requests are confirmed once buffered; the finish confirm
//   waits for the end of the inter-frame silence
`timescale 1ns/1ns
// Contract
// - Issue exactly one capability notice after start-up
// - Rate field gives worst-case bits per second after tolerances
// - Overhead field gives most bit periods spent on framing
// - Every payload unit in either direction is one octet
// - A frame-begin request starts the preamble and start delimiter
// - Data octets go out back to back in one transmission
// - Finish request sends end delimiter right after last octet
// - Every request gets exactly one confirm carrying a status
// - Final confirm waits until the line transmission has ended
// - Device alone paces the line; requests only via confirms
// - Raise frame-begin indication when line activity starts
// - One data indication per octet of a good reception
// - Good end delimiter gives a frame-finish indication
// - Malformed reception gives an end-with-error indication
// - Report begin, data, finish or begin, data, error
// - After an error suppress data and finish until a new begin
// - Confirm status is success or the local failure cause
module ophsp_port #(
  parameter int unsigned FIFO_DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Request and confirm
  input wire logic req_valid_in,
  input wire logic [1:0] req_class_in,
  input wire logic [7:0] req_octet_in,
  output logic cnf_valid_out,
  output logic [1:0] cnf_status_out,
  // Indications
  output logic ind_valid_out,
  output logic [1:0] ind_class_out,
  output logic [7:0] ind_octet_out,
  // Capability notice
  output logic notice_valid_out,
  output logic [ophsp_pkg::RATE_W-1:0] notice_rate_out,
  output logic [ophsp_pkg::OVH_W-1:0] notice_overhead_out,
  // Line transmit symbols
  output logic tx_active_out,
  output logic tx_sym_strobe_out,
  output logic tx_sym_ctrl_out,
  output logic [7:0] tx_sym_out,
  // Line receive symbols
  input wire logic rx_active_in,
  input wire logic rx_sym_strobe_in,
  input wire logic rx_sym_ctrl_in,
  input wire logic rx_sym_err_in,
  input wire logic [7:0] rx_sym_in
);
  import ophsp_pkg::*;

  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("ophsp_port: FIFO_DEPTH must be at least 2");
    end
  end

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_PRE = 3'h1,
    TX_SOF = 3'h2,
    TX_DATA = 3'h3,
    TX_EOF = 3'h4,
    TX_GAP = 3'h5
  } ophsp_tx_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_HUNT = 3'h1,
    RX_DATA = 3'h2,
    RX_TAIL = 3'h3,
    RX_DISCARD = 3'h4
  } ophsp_rx_t;

  localparam logic [4:0] SYM_LAST = 5'(SYM_CYCLES - 1);
  localparam logic [4:0] PRE_LAST = 5'(PRE_SYMS - 1);
  localparam logic [4:0] IFG_LAST = 5'(IFG_SYMS - 1);

  // Length check against the legal frame size
  function automatic logic len_ok(input logic [10:0] n);
    len_ok = (n >= MIN_OCTETS) && (n <= MAX_OCTETS);
  endfunction : len_ok

  // Request side state
  logic hold_ff;
  logic [1:0] hold_class_ff;
  logic [7:0] hold_octet_ff;
  logic in_frame_ff;
  logic fin_ff;
  logic go_ff;
  logic abort_ff;
  logic [10:0] len_ff;
  logic cnf_valid_ff;
  logic [1:0] cnf_status_ff;

  // Transmit state
  ophsp_tx_t tx_state_ff;
  ophsp_tx_t nxt_tx_state;
  logic [4:0] sym_cnt_ff;
  logic [4:0] left_ff;
  logic [4:0] nxt_left;
  logic tx_strobe_ff;
  logic tx_ctrl_ff;
  logic [7:0] tx_sym_ff;
  logic nxt_strobe;
  logic nxt_ctrl;
  logic [7:0] nxt_sym;
  logic tx_underrun;

  // FIFO wiring
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_pop;

  // Request decode
  // A new request is taken only while nothing is held
  wire take = req_valid_in && !hold_ff;
  wire hold_begin = hold_ff && (hold_class_ff == REQ_BEGIN);
  wire hold_data = hold_ff && (hold_class_ff == REQ_DATA);
  wire hold_fin = hold_ff && (hold_class_ff == REQ_FINISH);
  wire bad_class = hold_ff && (hold_class_ff == 2'h3);
  // Begin is refused while a frame is open or the line is still busy
  wire begin_bad = hold_begin &&
    (in_frame_ff || tx_state_ff != TX_IDLE || go_ff);
  wire begin_ok = hold_begin && !begin_bad;
  wire data_bad = hold_data && !in_frame_ff;
  wire data_drop = hold_data && in_frame_ff && abort_ff;
  wire data_push = hold_data && in_frame_ff && !abort_ff;
  wire data_done = data_push && fifo_in_ready;
  wire fin_bad = hold_fin && !in_frame_ff;
  // Finish accepted: the confirm waits for the line to fall idle
  wire fin_done = fin_ff && tx_state_ff == TX_IDLE && !go_ff;
  wire hold_clear = begin_ok || begin_bad || data_bad || data_drop ||
    data_done || fin_bad || bad_class || fin_done;
  wire hold_any_bad = begin_bad || data_bad || fin_bad || bad_class;

  // Confirm status for the request now finishing
  logic [1:0] nxt_status;
  always_comb begin
    nxt_status = ST_OK;
    if (hold_any_bad) begin
      nxt_status = ST_SEQUENCE;
    end else if (data_drop || (fin_done && abort_ff)) begin
      nxt_status = ST_UNDERRUN;
    end else if (fin_done && !len_ok(len_ff)) begin
      nxt_status = ST_LENGTH;
    end
  end

  // Hold register for the single outstanding request
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_ff <= 1'b0;
      hold_class_ff <= 2'h0;
      hold_octet_ff <= OCTET_RST;
    end else if (take) begin
      hold_ff <= 1'b1;
      hold_class_ff <= req_class_in;
      hold_octet_ff <= req_octet_in;
    end else if (hold_clear) begin
      hold_ff <= 1'b0;
    end
  end

  // One confirm per held request, as a single-cycle pulse
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnf_valid_ff <= 1'b0;
      cnf_status_ff <= ST_OK;
    end else begin
      cnf_valid_ff <= hold_clear;
      if (hold_clear) cnf_status_ff <= nxt_status;
    end
  end

  // Frame bookkeeping: open frame, pending finish, start token, length
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_frame_ff <= 1'b0;
      fin_ff <= 1'b0;
      go_ff <= 1'b0;
      len_ff <= LEN_RST;
    end else begin
      if (begin_ok) begin
        in_frame_ff <= 1'b1;
        go_ff <= 1'b1;
        len_ff <= LEN_RST;
      end else if (tx_state_ff == TX_IDLE) begin
        go_ff <= 1'b0;
      end
      if (data_done && len_ff != 11'h7FF) len_ff <= len_ff + 11'h001;
      if (hold_fin && in_frame_ff && !fin_ff) fin_ff <= 1'b1;
      if (fin_done) begin
        fin_ff <= 1'b0;
        in_frame_ff <= 1'b0;
      end
    end
  end

  // Underrun latches until the frame's finish has been confirmed
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      abort_ff <= 1'b0;
    end else if (tx_underrun) begin
      abort_ff <= 1'b1;
    end else if (fin_done || begin_ok) begin
      abort_ff <= 1'b0;
    end
  end

  // Transmit buffer
  ophsp_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(data_push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(hold_octet_ff),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_out_data)
  );

  // Transmit sequencer
  // The symbol timer alone sets line timing; requests never pace it
  wire sym_tick = (tx_state_ff != TX_IDLE) && (sym_cnt_ff == 5'h00);
  wire data_tick = sym_tick && tx_state_ff == TX_DATA;
  // An empty buffer mid-frame cannot be bridged, so the frame is aborted
  assign tx_underrun = data_tick && !fifo_out_valid && !fin_ff;
  // Leftover octets of an aborted frame are flushed off the line
  assign fifo_pop = (data_tick && fifo_out_valid) ||
    (abort_ff && fifo_out_valid && tx_state_ff != TX_DATA);

  always_comb begin
    nxt_tx_state = tx_state_ff;
    nxt_left = left_ff;
    nxt_strobe = 1'b0;
    nxt_ctrl = 1'b1;
    nxt_sym = SYM_PRE;
    case (tx_state_ff)
      TX_IDLE: begin
        if (go_ff) begin
          nxt_tx_state = TX_PRE;
          nxt_left = PRE_LAST;
        end
      end
      TX_PRE: begin
        if (sym_tick) begin
          nxt_strobe = 1'b1;
          nxt_left = left_ff - 5'h01;
          if (left_ff == 5'h00) nxt_tx_state = TX_SOF;
        end
      end
      TX_SOF: begin
        if (sym_tick) begin
          nxt_strobe = 1'b1;
          nxt_sym = SYM_SOF;
          nxt_tx_state = TX_DATA;
        end
      end
      TX_DATA: begin
        if (sym_tick) begin
          nxt_strobe = 1'b1;
          if (fifo_out_valid) begin
            nxt_ctrl = 1'b0;
            nxt_sym = fifo_out_data;
          end else if (fin_ff) begin
            nxt_sym = SYM_EOF;
            nxt_tx_state = TX_GAP;
            nxt_left = IFG_LAST;
          end else begin
            nxt_sym = SYM_ABORT;
            nxt_tx_state = TX_GAP;
            nxt_left = IFG_LAST;
          end
        end
      end
      TX_EOF: begin
        nxt_tx_state = TX_GAP;
        nxt_left = IFG_LAST;
      end
      TX_GAP: begin
        if (sym_tick) begin
          nxt_left = left_ff - 5'h01;
          if (left_ff == 5'h00) nxt_tx_state = TX_IDLE;
        end
      end
      default: begin
        nxt_tx_state = TX_IDLE;
      end
    endcase
  end

  // Sequencer state, symbol timer and symbol output registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_state_ff <= TX_IDLE;
      sym_cnt_ff <= SYM_LAST;
      left_ff <= 5'h00;
      tx_strobe_ff <= 1'b0;
      tx_ctrl_ff <= 1'b0;
      tx_sym_ff <= OCTET_RST;
    end else begin
      tx_state_ff <= nxt_tx_state;
      left_ff <= nxt_left;
      if (tx_state_ff == TX_IDLE || sym_cnt_ff == 5'h00) begin
        sym_cnt_ff <= SYM_LAST;
      end else begin
        sym_cnt_ff <= sym_cnt_ff - 5'h01;
      end
      tx_strobe_ff <= nxt_strobe;
      if (nxt_strobe) begin
        tx_ctrl_ff <= nxt_ctrl;
        tx_sym_ff <= nxt_sym;
      end
    end
  end

  // Driver is on from preamble until the last delimiter is strobed, dropping in that same cycle
  logic tx_active_ff;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_active_ff <= 1'b0;
    end else begin
      tx_active_ff <= (nxt_tx_state != TX_IDLE) &&
        (nxt_tx_state != TX_GAP);
    end
  end

  // Receive framing
  ophsp_rx_t rx_state_ff;
  ophsp_rx_t nxt_rx_state;
  logic rx_prev_ff;
  logic ind_valid_ff;
  logic [1:0] ind_class_ff;
  logic [7:0] ind_octet_ff;
  logic nxt_ind;
  logic [1:0] nxt_ind_class;

  wire rx_rise = rx_active_in && !rx_prev_ff;
  wire rx_sym = rx_sym_strobe_in && rx_active_in;
  wire rx_bad = rx_sym && rx_sym_err_in;
  wire rx_octet = rx_sym && !rx_sym_err_in && !rx_sym_ctrl_in;
  wire rx_is_sof = rx_sym && !rx_sym_err_in && rx_sym_ctrl_in &&
    rx_sym_in == SYM_SOF;
  wire rx_is_eof = rx_sym && !rx_sym_err_in && rx_sym_ctrl_in &&
    rx_sym_in == SYM_EOF;
  wire rx_is_pre = rx_sym && !rx_sym_err_in && rx_sym_ctrl_in &&
    rx_sym_in == SYM_PRE;

  always_comb begin
    nxt_rx_state = rx_state_ff;
    nxt_ind = 1'b0;
    nxt_ind_class = IND_BEGIN;
    case (rx_state_ff)
      RX_IDLE: begin
        if (rx_rise) begin
          nxt_ind = 1'b1;
          nxt_rx_state = RX_HUNT;
        end
      end
      RX_HUNT: begin
        if (!rx_active_in || rx_bad || rx_octet ||
            (rx_sym && !rx_is_pre && !rx_is_sof)) begin
          nxt_ind = 1'b1;
          nxt_ind_class = IND_ERROR;
          nxt_rx_state = rx_active_in ? RX_DISCARD : RX_IDLE;
        end else if (rx_is_sof) begin
          nxt_rx_state = RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_octet) begin
          nxt_ind = 1'b1;
          nxt_ind_class = IND_DATA;
        end else if (rx_is_eof) begin
          nxt_ind = 1'b1;
          nxt_ind_class = IND_FINISH;
          nxt_rx_state = RX_TAIL;
        end else if (!rx_active_in || rx_sym) begin
          nxt_ind = 1'b1;
          nxt_ind_class = IND_ERROR;
          nxt_rx_state = rx_active_in ? RX_DISCARD : RX_IDLE;
        end
      end
      RX_TAIL, RX_DISCARD: begin
        // Nothing is reported until activity ends and restarts
        if (!rx_active_in) nxt_rx_state = RX_IDLE;
      end
      default: begin
        nxt_rx_state = RX_IDLE;
      end
    endcase
  end

  // Receive state and indication registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_state_ff <= RX_IDLE;
      rx_prev_ff <= 1'b0;
      ind_valid_ff <= 1'b0;
      ind_class_ff <= IND_BEGIN;
      ind_octet_ff <= OCTET_RST;
    end else begin
      rx_state_ff <= nxt_rx_state;
      rx_prev_ff <= rx_active_in;
      ind_valid_ff <= nxt_ind;
      if (nxt_ind) begin
        ind_class_ff <= nxt_ind_class;
        ind_octet_ff <= (nxt_ind_class == IND_DATA) ? rx_sym_in : OCTET_RST;
      end
    end
  end

  // Capability notice
  // Fields are constant; the pulse fires once on the first edge after reset
  logic notice_sent_ff;
  logic notice_valid_ff;
  logic [RATE_W-1:0] rate_ff;
  logic [OVH_W-1:0] ovh_ff;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      notice_sent_ff <= 1'b0;
      notice_valid_ff <= 1'b0;
      rate_ff <= RATE_W'(MIN_BPS);
      ovh_ff <= OVH_W'(OVERHEAD_BITS);
    end else begin
      notice_sent_ff <= 1'b1;
      notice_valid_ff <= !notice_sent_ff;
    end
  end

  // Outputs
  assign cnf_valid_out = cnf_valid_ff;
  assign cnf_status_out = cnf_status_ff;
  assign ind_valid_out = ind_valid_ff;
  assign ind_class_out = ind_class_ff;
  assign ind_octet_out = ind_octet_ff;
  assign notice_valid_out = notice_valid_ff;
  assign notice_rate_out = rate_ff;
  assign notice_overhead_out = ovh_ff;
  assign tx_active_out = tx_active_ff;
  assign tx_sym_strobe_out = tx_strobe_ff;
  assign tx_sym_ctrl_out = tx_ctrl_ff;
  assign tx_sym_out = tx_sym_ff;

endmodule : ophsp_port

/* bench/ophsp_port_sva.sv */
// Purpose: Concurrent checks on the octet service port
// Assumes: One clock, asynchronous active-low reset
// Notes: Helper logic tracks the single outstanding request
`timescale 1ns/1ns
module ophsp_port_chk #(
  parameter int unsigned FIFO_DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire logic [1:0] req_class_in,
  input wire logic cnf_valid_out,
  input wire logic [1:0] cnf_status_out,
  input wire logic ind_valid_out,
  input wire logic [1:0] ind_class_out,
  input wire logic [7:0] ind_octet_out,
  input wire logic notice_valid_out,
  input wire logic [ophsp_pkg::RATE_W-1:0] notice_rate_out,
  input wire logic tx_active_out,
  input wire logic tx_sym_strobe_out,
  input wire logic tx_sym_ctrl_out,
  input wire logic [7:0] tx_sym_out,
  input wire logic rx_active_in,
  input wire logic rx_sym_strobe_in,
  input wire logic [7:0] rx_sym_in
);
  import ophsp_pkg::*;
  logic pend_ff;
  logic seen_ff;
  // A confirm edge may also take the next request
  wire take = req_valid_in & ~(pend_ff & ~cnf_valid_out);
  wire last_sym = tx_sym_ctrl_out &&
    (tx_sym_out == SYM_EOF || tx_sym_out == SYM_ABORT);

  // Outstanding request and notice bookkeeping
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_ff <= 1'b0;
      seen_ff <= 1'b0;
    end else begin
      pend_ff <= take | (pend_ff & ~cnf_valid_out);
      seen_ff <= seen_ff | notice_valid_out;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // One symbol period is 16 clocks
  sequence s_tick;
    ##16 tx_sym_strobe_out;
  endsequence
  sequence s_pre;
    ##16 (tx_sym_strobe_out && tx_sym_ctrl_out && tx_sym_out == SYM_PRE);
  endsequence

  AST_ONE_NOTICE: assert property (
    notice_valid_out |-> !seen_ff) else $error("second notice");
  AST_RATE: assert property (
    notice_valid_out |-> notice_rate_out == 32'h0098_9298)
    else $error("notice rate wrong");
  AST_BEGIN_CNF: assert property (
    take && req_class_in == 2'h0 |-> ##2 cnf_valid_out)
    else $error("begin confirm late");
  AST_BAD_CLASS: assert property (
    take && req_class_in == 2'h3 |-> ##2
    (cnf_valid_out && cnf_status_out == 2'h1)) else $error("class 3 taken");
  AST_CNF_OWNED: assert property (
    cnf_valid_out |-> pend_ff && !$past(cnf_valid_out))
    else $error("stray confirm");
  AST_PRE: assert property (
    $rose(tx_active_out) |-> s_pre) else $error("no preamble");
  AST_GAPLESS: assert property (
    tx_sym_strobe_out && tx_active_out && !last_sym |-> s_tick)
    else $error("gap on line");
  AST_RX_BEGIN: assert property (
    $rose(rx_active_in) |=> ind_valid_out && ind_class_out == 2'h0)
    else $error("no begin indication");
  AST_RX_DATA: assert property (
    ind_valid_out && ind_class_out == 2'h1 |-> $past(rx_sym_strobe_in)
    && $past(rx_sym_in) == ind_octet_out) else $error("data octet wrong");
  AST_RX_FIN: assert property (
    ind_valid_out && ind_class_out == 2'h2 |-> $past(rx_sym_strobe_in)
    && $past(rx_sym_in) == SYM_EOF) else $error("finish without end");
endmodule : ophsp_port_chk

bind ophsp_port ophsp_port_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .clk_in, .rst_n_in, .req_valid_in, .req_class_in, .cnf_valid_out,
  .cnf_status_out, .ind_valid_out, .ind_class_out, .ind_octet_out,
  .notice_valid_out, .notice_rate_out, .tx_active_out, .tx_sym_strobe_out,
  .tx_sym_ctrl_out, .tx_sym_out, .rx_active_in, .rx_sym_strobe_in,
  .rx_sym_in);

/* bench/ophsp_link_model.sv */
// Purpose: Link entity model issuing requests and awaiting confirms
// Assumes: Requests are one-cycle pulses
// Notes: Stale octet is inverted once the strobe drops
`timescale 1ns/1ns
module ophsp_link_model (
  input wire logic clk_in,
  input wire logic cnf_valid_in,
  input wire logic [1:0] cnf_status_in,
  output logic req_valid_out,
  output logic [1:0] req_class_out,
  output logic [7:0] req_octet_out
);
  initial begin
    req_valid_out = 1'b0;
    req_class_out = 2'h0;
    req_octet_out = 8'h00;
  end

  // One pulse, then no new request until its confirm
  task automatic req(input logic [1:0] c, input logic [7:0] o,
      output logic [1:0] st, output int w);
    st = 2'hX;
    @(posedge clk_in) #2;
    req_valid_out = 1'b1;
    req_class_out = c;
    req_octet_out = o;
    @(posedge clk_in) #2;
    req_valid_out = 1'b0;
    req_octet_out = ~o;
    for (w = 1; w < 3000 && cnf_valid_in !== 1'b1; w++) begin
      @(posedge clk_in) #2;
    end
    if (w < 3000) st = cnf_status_in;
  endtask : req
endmodule : ophsp_link_model

/* bench/ophsp_port_tb.sv */
// Purpose: Self-checking bench for the octet service port
// Assumes: 20 MHz clock, inputs driven 2 ns after the rising edge
// Notes: Line symbols and indications are logged at each edge
`timescale 1ns/1ns
module ophsp_port_tb;
  import ophsp_pkg::*;
  localparam longint EXP_RATE = longint'(CLK_HZ) / SYM_CYCLES *
    BITS_PER_SYM * (1_000_000 - TOL_PPM) / 1_000_000;
  logic clk_in, rst_n_in, req_valid_in, cnf_valid_out, ind_valid_out;
  logic [1:0] req_class_in, cnf_status_out, ind_class_out, st;
  logic [7:0] req_octet_in, ind_octet_out, tx_sym_out, rx_sym_in;
  logic notice_valid_out, tx_active_out, tx_sym_strobe_out, tx_sym_ctrl_out;
  logic [RATE_W-1:0] notice_rate_out;
  logic [OVH_W-1:0] notice_overhead_out;
  logic rx_active_in, rx_sym_strobe_in, rx_sym_ctrl_in, rx_sym_err_in;
  int err_total = 0, checked = 0, cyc = 0, eof_cyc = 0, notices = 0, w;
  logic [8:0] txq[$];
  logic [9:0] indq[$];

  ophsp_port #(.FIFO_DEPTH(4)) uut (.clk_in, .rst_n_in, .req_valid_in,
    .req_class_in, .req_octet_in, .cnf_valid_out, .cnf_status_out,
    .ind_valid_out, .ind_class_out, .ind_octet_out, .notice_valid_out,
    .notice_rate_out, .notice_overhead_out, .tx_active_out,
    .tx_sym_strobe_out, .tx_sym_ctrl_out, .tx_sym_out, .rx_active_in,
    .rx_sym_strobe_in, .rx_sym_ctrl_in, .rx_sym_err_in, .rx_sym_in);
  ophsp_link_model link (.clk_in, .cnf_valid_in(cnf_valid_out),
    .cnf_status_in(cnf_status_out), .req_valid_out(req_valid_in),
    .req_class_out(req_class_in), .req_octet_out(req_octet_in));

  initial clk_in = 1'b0;
  always #25 clk_in = ~clk_in;

  task automatic check(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Log outputs at the edge that samples them
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (tx_sym_strobe_out === 1'b1) begin
      txq.push_back({tx_sym_ctrl_out, tx_sym_out});
      if (tx_sym_ctrl_out && tx_sym_out == SYM_EOF) eof_cyc = cyc;
    end
    if (ind_valid_out === 1'b1) indq.push_back({ind_class_out, ind_octet_out});
    if (notice_valid_out === 1'b1) begin
      notices++;
      check(notice_rate_out, EXP_RATE[31:0]);
      check(notice_overhead_out, (PRE_SYMS + 2 + IFG_SYMS) * 8);
    end
  end

  task automatic rx_put(input logic c, input logic e, input logic [7:0] s);
    @(posedge clk_in) #2;
    rx_sym_strobe_in = 1'b1;
    rx_sym_ctrl_in = c;
    rx_sym_err_in = e;
    rx_sym_in = s;
    @(posedge clk_in) #2;
    rx_sym_strobe_in = 1'b0;
    rx_sym_err_in = 1'b0;
    rx_sym_in = ~s;
    repeat (3) @(posedge clk_in);
  endtask : rx_put

  task automatic rx_act(input logic a);
    @(posedge clk_in) #2;
    rx_active_in = a;
    repeat (3) @(posedge clk_in);
  endtask : rx_act

  // Refusals outside a frame, a doubled begin, an empty frame
  task automatic t_refuse;
    for (int c = 1; c < 4; c++) begin
      link.req(2'(c), 8'h00, st, w);
      check(st, ST_SEQUENCE);
    end
    check(txq.size(), 0);
    link.req(2'h0, 8'h00, st, w);
    check(st, ST_OK);
    link.req(2'h0, 8'h00, st, w);
    check(st, ST_SEQUENCE);
    link.req(2'h2, 8'h00, st, w);
    check(st, ST_LENGTH);
    check(txq[$], {1'b1, SYM_EOF});
  endtask : t_refuse

  // Shortest legal frame; the buffer fills and holds confirms back
  task automatic t_frame(input int n);
    int maxw = 0;
    txq.delete();
    link.req(2'h0, 8'h00, st, w);
    check(st, ST_OK);
    for (int i = 0; i < n; i++) begin
      link.req(2'h1, 8'(i * 3 + 1), st, w);
      check(st, ST_OK);
      if (w > maxw) maxw = w;
    end
    link.req(2'h2, 8'h00, st, w);
    check(st, ST_OK);
    check(cyc - eof_cyc >= IFG_SYMS * SYM_CYCLES, 1);
    check(maxw > 10, 1);
    check(txq.size(), PRE_SYMS + n + 2);
    foreach (txq[i]) check(txq[i], i < PRE_SYMS ? {1'b1, SYM_PRE} :
      i == PRE_SYMS ? {1'b1, SYM_SOF} : i == n + 8 ? {1'b1, SYM_EOF} :
      {1'b0, 8'((i - 8) * 3 + 1)});
  endtask : t_frame

  // Starved line aborts; later requests report the underrun
  task automatic t_underrun;
    txq.delete();
    link.req(2'h0, 8'h00, st, w);
    link.req(2'h1, 8'hA5, st, w);
    repeat (400) @(posedge clk_in);
    check(txq[$], {1'b1, SYM_ABORT});
    link.req(2'h1, 8'h5A, st, w);
    check(st, ST_UNDERRUN);
    link.req(2'h2, 8'h00, st, w);
    check(st, ST_UNDERRUN);
  endtask : t_underrun

  task automatic t_rx_good;
    indq.delete();
    rx_act(1'b1);
    rx_put(1'b1, 1'b0, SYM_PRE);
    rx_put(1'b1, 1'b0, SYM_SOF);
    rx_put(1'b0, 1'b0, 8'h11);
    rx_put(1'b0, 1'b0, 8'h22);
    rx_put(1'b1, 1'b0, SYM_EOF);
    rx_act(1'b0);
    check(indq.size(), 4);
    check(indq[0], 10'h000);
    check(indq[2], {2'h1, 8'h22});
    check(indq[3], {2'h2, 8'h00});
  endtask : t_rx_good

  // Malformed symbol mid-frame, then silence until a new activity
  task automatic t_rx_err;
    indq.delete();
    rx_act(1'b1);
    rx_put(1'b1, 1'b0, SYM_SOF);
    rx_put(1'b0, 1'b0, 8'h44);
    rx_put(1'b0, 1'b1, 8'h45);
    rx_put(1'b0, 1'b0, 8'h46);
    rx_put(1'b1, 1'b0, SYM_EOF);
    rx_act(1'b0);
    rx_act(1'b1);
    rx_put(1'b1, 1'b0, SYM_SOF);
    rx_put(1'b1, 1'b0, SYM_EOF);
    rx_act(1'b0);
    check(indq.size(), 5);
    check(indq[1], {2'h1, 8'h44});
    check(indq[2], {2'h3, 8'h00});
    check(indq[3], 10'h000);
    check(indq[4], {2'h2, 8'h00});
  endtask : t_rx_err

  initial begin
    rst_n_in = 1'b0;
    rx_active_in = 1'b0;
    rx_sym_strobe_in = 1'b0;
    rx_sym_ctrl_in = 1'b0;
    rx_sym_err_in = 1'b0;
    rx_sym_in = 8'h00;
    repeat (10) @(posedge clk_in);
    #2;
    rst_n_in = 1'b1;
    t_refuse();
    t_frame(72);
    t_underrun();
    t_rx_good();
    t_rx_err();
    check(notices, 1);
    test_done();
  end

  // Whole run needs well under 10000 clocks
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    test_done();
  end
endmodule : ophsp_port_tb
